// >>> design/flk_consts.svh
`ifndef FLK_CONSTS_SVH
`define FLK_CONSTS_SVH

// Control register field positions.
`define FLK_CSR_STORE_EN 0
`define FLK_CSR_PG_ERASE 1
`define FLK_CSR_PG_WRITE 2
`define FLK_CSR_RD_SELECT 3
`define FLK_CSR_CLR_BUF 4

// Values of the control register's lower five bits; all but FLK_CMD_NONE are accepted.
`define FLK_CMD_CLR_BUF 5'h11
`define FLK_CMD_FUSE_READ 5'h09
`define FLK_CMD_PG_WRITE 5'h05
`define FLK_CMD_PG_ERASE 5'h03
`define FLK_CMD_FILL 5'h01
`define FLK_CMD_NONE 5'h00

// Pointer values that select a readback byte.
`define FLK_Z_FUSE_LOW 16'h0000
`define FLK_Z_LOCK 16'h0001
`define FLK_Z_FUSE_HIGH 16'h0003

// Window ages, counted from 0 in the cycle after the control write.
`define FLK_LPM_LAST 3'h2
`define FLK_SPM_LAST 3'h3
`define FLK_AGE_ZERO 3'h0
`define FLK_AGE_STEP 3'h1

// Flash operation timing.
`define FLK_FLASH_MIN_US 3700
`define FLK_FLASH_MAX_US 4500
`define FLK_CLK_MHZ 20
`define FLK_CNT_ZERO 17'h00000
`define FLK_CNT_STEP 17'h00001

// Lock byte layout and values.
`define FLK_LOCK_PAD 6'h3f
`define FLK_LOCK_ERASED 2'h3
`define FLK_LOCK_MODE2 2'h2
`define FLK_UNMAPPED_BYTE 8'hff
`define FLK_MODE_1 2'h1
`define FLK_MODE_2 2'h2
`define FLK_MODE_3 2'h3
`define FLK_CSR_PAD 3'h0

`endif

// >>> design/flk_pkg.sv
package flk_pkg;

  typedef enum logic [1:0] {
    FLK_ST_IDLE = 2'h0,
    FLK_ST_ARM = 2'h1,
    FLK_ST_LOAD = 2'h3
  } flk_ctl_state_t;

  typedef enum logic {
    FLK_OP_IDLE = 1'h0,
    FLK_OP_RUN = 1'h1
  } flk_op_state_t;

  typedef enum logic [1:0] {
    FLK_KIND_ERASE = 2'h0,
    FLK_KIND_WRITE = 2'h1,
    FLK_KIND_LOCK = 2'h2
  } flk_op_kind_t;

  typedef struct packed {
    flk_ctl_state_t state;
    logic [4:0] csr;
    logic [2:0] age;
    logic running;
    logic fuse_rd;
    logic [15:0] zsel;
    logic [15:0] pm_addr;
    logic lpm_valid;
    logic [7:0] lpm_data;
    logic ee_busy;
    logic [7:0] fl_s1;
    logic [7:0] fl_s2;
    logic [7:0] fh_s1;
    logic [7:0] fh_s2;
    logic buf_load;
    logic buf_clear;
    logic [15:0] buf_data;
  } flk_ctl_t;

  typedef struct packed {
    flk_op_state_t state;
    flk_op_kind_t kind;
    logic [16:0] cnt;
    logic [1:0] lock;
    logic [1:0] lock_data;
    logic erase_p;
    logic write_p;
    logic busy;
    logic done;
    logic [1:0] mode;
    logic prog_allow;
    logic verify_allow;
    logic fuse_wr_allow;
    logic lock_wr_allow;
  } flk_op_t;

  typedef struct packed {
    logic csr_wr;
    logic [7:0] csr_wdata;
    logic lpm_req;
    logic spm_req;
    logic [15:0] z_ptr;
    logic [15:0] spm_data;
    logic lpm_valid;
    logic [7:0] lpm_data;
    logic refused;
    logic halt;
    logic [7:0] csr_read;
  } flk_cpu_t;

endpackage

// >>> design/flk_link_if.sv
`timescale 1ns/1ps
interface flk_link_if;
  logic csr_wr;
  logic [7:0] csr_wdata;
  logic [7:0] csr_rdata;
  logic lpm_req;
  logic spm_req;
  logic [15:0] z_ptr;
  logic [15:0] spm_data;
  logic lpm_valid;
  logic [7:0] lpm_data;
  logic halt;
  logic ee_busy;

  modport dev (
    input csr_wr, csr_wdata, lpm_req, spm_req, z_ptr, spm_data,
    output csr_rdata, lpm_valid, lpm_data, halt, ee_busy
  );
  modport cpu (
    output csr_wr, csr_wdata, lpm_req, spm_req, z_ptr, spm_data,
    input csr_rdata, lpm_valid, lpm_data, halt, ee_busy
  );
endinterface

// >>> design/flk_ctrl.sv
`timescale 1ns/1ps
`include "flk_consts.svh"

module flk_ctrl
  import flk_pkg::*;
#(
  parameter int unsigned FLASH_OP_CYCLES = `FLK_FLASH_MIN_US * `FLK_CLK_MHZ
) (
  input wire logic sys_clk, // Core clock, the calibrated RC oscillator.
  input wire logic rst, // System reset, active high.
  input wire logic por, // Power-on reset for the flash timer, active high.
  flk_link_if.dev link, // Core side.
  input wire logic eeprom_write_busy, // EEPROM write in progress.
  input wire logic chip_erase, // Chip erase command strobe.
  input wire logic [7:0] fuse_low_byte, // Fuse low byte cells.
  input wire logic [7:0] fuse_high_byte, // Fuse high byte cells.
  input wire logic [7:0] pm_rdata, // Program memory byte at pm_addr.
  output logic [15:0] pm_addr, // Program memory byte address.
  output logic buf_load, // Page buffer word write pulse.
  output logic [15:0] buf_data, // Page buffer word.
  output logic buf_clear, // Page buffer clear pulse.
  output logic page_erase, // Page erase start pulse.
  output logic page_write, // Page write start pulse.
  output logic flash_busy, // Flash operation under way.
  output logic [1:0] prot_mode, // Protection mode 1, 2 or 3.
  output logic ext_prog_allow, // External flash and EEPROM programming allowed.
  output logic ext_verify_allow, // External verification allowed.
  output logic ext_fuse_wr_allow, // External fuse writes allowed.
  output logic ext_lock_wr_allow // External lock writes allowed.
);

  localparam logic [16:0] OP_LAST = 17'(FLASH_OP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic cmd_legal(input logic [4:0] cmd);
    cmd_legal = (cmd == `FLK_CMD_CLR_BUF) || (cmd == `FLK_CMD_FUSE_READ) ||
                (cmd == `FLK_CMD_PG_WRITE) || (cmd == `FLK_CMD_PG_ERASE) ||
                (cmd == `FLK_CMD_FILL);
  endfunction

  function automatic logic [7:0] readback(input logic [15:0] z, input logic [1:0] lock,
                                          input logic [7:0] flo, input logic [7:0] fhi);
    if (z == `FLK_Z_LOCK) begin
      readback = {`FLK_LOCK_PAD, lock};
    end else if (z == `FLK_Z_FUSE_LOW) begin
      readback = flo;
    end else if (z == `FLK_Z_FUSE_HIGH) begin
      readback = fhi;
    end else begin
      readback = `FLK_UNMAPPED_BYTE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  flk_ctl_t q;
  flk_ctl_t n;
  flk_op_t o;
  flk_op_t no;
  logic start;
  flk_op_kind_t start_kind;

  // Control side: arming, windows and readback.
  always_comb begin
    n = q;
    start = 1'b0;
    start_kind = FLK_KIND_ERASE;
    n.lpm_valid = 1'b0;
    n.buf_load = 1'b0;
    n.buf_clear = 1'b0;
    n.ee_busy = eeprom_write_busy;
    n.fl_s1 = fuse_low_byte;
    n.fl_s2 = q.fl_s1;
    n.fh_s1 = fuse_high_byte;
    n.fh_s2 = q.fh_s1;
    if ((q.csr != `FLK_CMD_NONE) && !q.running) begin
      n.age = q.age + `FLK_AGE_STEP;
      if (q.age == `FLK_SPM_LAST) begin
        n.csr = `FLK_CMD_NONE;
      end
    end
    case (q.state)
      FLK_ST_IDLE: begin
        if (link.csr_wr && cmd_legal(link.csr_wdata[4:0]) && (o.state == FLK_OP_IDLE)) begin
          // A programming command is dropped while the EEPROM is writing.
          if (link.csr_wdata[4:0] == `FLK_CMD_FUSE_READ || !eeprom_write_busy) begin
            n.csr = link.csr_wdata[4:0];
            n.age = `FLK_AGE_ZERO;
            n.state = FLK_ST_ARM;
          end
        end else if (link.lpm_req) begin
          n.pm_addr = link.z_ptr;
          n.fuse_rd = 1'b0;
          n.state = FLK_ST_LOAD;
        end
      end
      FLK_ST_ARM: begin
        if (q.running) begin
          if (o.done) begin
            n.csr = `FLK_CMD_NONE;
            n.running = 1'b0;
            n.state = FLK_ST_IDLE;
          end
        end else if (q.csr == `FLK_CMD_NONE) begin
          n.state = FLK_ST_IDLE;
          if (link.lpm_req) begin
            n.pm_addr = link.z_ptr;
            n.fuse_rd = 1'b0;
            n.state = FLK_ST_LOAD;
          end
        end else if (link.lpm_req) begin
          n.pm_addr = link.z_ptr;
          n.zsel = link.z_ptr;
          n.state = FLK_ST_LOAD;
          n.fuse_rd = 1'b0;
          if (q.csr[`FLK_CSR_RD_SELECT] && q.csr[`FLK_CSR_STORE_EN] &&
              (q.age <= `FLK_LPM_LAST) && !eeprom_write_busy) begin
            n.fuse_rd = 1'b1;
            n.csr = `FLK_CMD_NONE;
          end
        end else if (link.spm_req) begin
          n.csr = `FLK_CMD_NONE;
          case (q.csr)
            `FLK_CMD_FILL: begin
              n.buf_load = 1'b1;
              n.buf_data = link.spm_data;
            end
            `FLK_CMD_CLR_BUF: begin
              n.buf_clear = 1'b1;
            end
            `FLK_CMD_PG_ERASE, `FLK_CMD_PG_WRITE, `FLK_CMD_FUSE_READ: begin
              if (!eeprom_write_busy) begin
                start = 1'b1;
                n.csr = q.csr;
                n.running = 1'b1;
                if (q.csr == `FLK_CMD_PG_ERASE) begin
                  start_kind = FLK_KIND_ERASE;
                end else if (q.csr == `FLK_CMD_PG_WRITE) begin
                  start_kind = FLK_KIND_WRITE;
                end else begin
                  start_kind = FLK_KIND_LOCK;
                end
              end
            end
            default: begin
              n.csr = `FLK_CMD_NONE;
            end
          endcase
        end
      end
      FLK_ST_LOAD: begin
        n.lpm_valid = 1'b1;
        n.lpm_data = q.fuse_rd ? readback(q.zsel, o.lock, q.fl_s2, q.fh_s2) : pm_rdata;
        n.fuse_rd = 1'b0;
        n.state = (n.csr != `FLK_CMD_NONE) ? FLK_ST_ARM : FLK_ST_IDLE;
      end
      default: begin
        n.state = FLK_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Flash timer and lock cells; power-on reset clears the timer and sets the lock cells to erased (all ones), and chip erase also sets the lock cells to erased.
  always_comb begin
    no = o;
    no.erase_p = 1'b0;
    no.write_p = 1'b0;
    no.done = 1'b0;
    case (o.state)
      FLK_OP_IDLE: begin
        if (start) begin
          no.state = FLK_OP_RUN;
          no.kind = start_kind;
          no.cnt = `FLK_CNT_ZERO;
          no.lock_data = link.spm_data[1:0];
          no.erase_p = (start_kind == FLK_KIND_ERASE);
          no.write_p = (start_kind == FLK_KIND_WRITE);
          no.busy = 1'b1;
        end
      end
      FLK_OP_RUN: begin
        no.cnt = o.cnt + `FLK_CNT_STEP;
        if (o.cnt == OP_LAST) begin
          no.state = FLK_OP_IDLE;
          no.busy = 1'b0;
          no.done = 1'b1;
          if (o.kind == FLK_KIND_LOCK) begin
            no.lock = o.lock & o.lock_data;
          end
        end
      end
      default: begin
        no.state = FLK_OP_IDLE;
      end
    endcase
    if (chip_erase) begin
      no.lock = `FLK_LOCK_ERASED;
    end
    no.mode = (no.lock == `FLK_LOCK_ERASED) ? `FLK_MODE_1 :
              (no.lock == `FLK_LOCK_MODE2) ? `FLK_MODE_2 : `FLK_MODE_3;
    no.prog_allow = (no.mode == `FLK_MODE_1);
    no.fuse_wr_allow = (no.mode == `FLK_MODE_1);
    no.verify_allow = (no.mode != `FLK_MODE_3);
    no.lock_wr_allow = (no.mode != `FLK_MODE_3);
  end

  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      o <= '{state: FLK_OP_IDLE, kind: FLK_KIND_ERASE, cnt: `FLK_CNT_ZERO,
             lock: `FLK_LOCK_ERASED, lock_data: `FLK_LOCK_ERASED, mode: `FLK_MODE_1,
             prog_allow: 1'b1, verify_allow: 1'b1, fuse_wr_allow: 1'b1,
             lock_wr_allow: 1'b1, default: 1'b0};
    end else begin
      o <= no;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign link.csr_rdata = {`FLK_CSR_PAD, q.csr};
  assign link.lpm_valid = q.lpm_valid;
  assign link.lpm_data = q.lpm_data;
  assign link.halt = o.busy;
  assign link.ee_busy = q.ee_busy;
  assign pm_addr = q.pm_addr;
  assign buf_load = q.buf_load;
  assign buf_data = q.buf_data;
  assign buf_clear = q.buf_clear;
  assign page_erase = o.erase_p;
  assign page_write = o.write_p;
  assign flash_busy = o.busy;
  assign prot_mode = o.mode;
  assign ext_prog_allow = o.prog_allow;
  assign ext_verify_allow = o.verify_allow;
  assign ext_fuse_wr_allow = o.fuse_wr_allow;
  assign ext_lock_wr_allow = o.lock_wr_allow;

endmodule

// >>> design/flk_cpu.sv
`timescale 1ns/1ps
`include "flk_consts.svh"

module flk_cpu
  import flk_pkg::*;
(
  input wire logic sys_clk, // Core clock.
  input wire logic rst, // System reset, active high.
  flk_link_if.cpu link, // Device side.
  input wire logic u_csr_wr, // Request a control register write.
  input wire logic [7:0] u_csr_val, // Value to write.
  input wire logic u_lpm, // Request a program memory load.
  input wire logic u_spm, // Request a program store.
  input wire logic [15:0] u_z, // Address pointer for the load or store.
  input wire logic [15:0] u_spm_data, // Store word.
  input wire logic u_sleep, // Core in power-down sleep.
  output logic u_lpm_valid, // Load result valid pulse.
  output logic [7:0] u_lpm_data, // Load result.
  output logic u_refused, // Control write withheld pulse.
  output logic u_halt, // Core halted by a flash operation.
  output logic [7:0] u_csr_read // Control register contents.
);

  flk_cpu_t q;
  flk_cpu_t n;
  logic may_write;

  always_comb begin
    n = q;
    // Writes need an idle EEPROM and an awake, running core; others are refused.
    may_write = !link.ee_busy && !u_sleep && !link.halt;
    n.csr_wr = u_csr_wr && may_write;
    n.refused = u_csr_wr && !may_write;
    if (u_csr_wr) begin
      n.csr_wdata = u_csr_val;
    end
    n.lpm_req = u_lpm && !u_sleep && !link.halt;
    n.spm_req = u_spm && !u_sleep && !link.halt;
    if (u_lpm || u_spm) begin
      n.z_ptr = u_z;
      n.spm_data = u_spm_data;
    end
    n.lpm_valid = link.lpm_valid;
    if (link.lpm_valid) begin
      n.lpm_data = link.lpm_data;
    end
    n.halt = link.halt;
    n.csr_read = link.csr_rdata;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign link.csr_wr = q.csr_wr;
  assign link.csr_wdata = q.csr_wdata;
  assign link.lpm_req = q.lpm_req;
  assign link.spm_req = q.spm_req;
  assign link.z_ptr = q.z_ptr;
  assign link.spm_data = q.spm_data;
  assign u_lpm_valid = q.lpm_valid;
  assign u_lpm_data = q.lpm_data;
  assign u_refused = q.refused;
  assign u_halt = q.halt;
  assign u_csr_read = q.csr_read;

endmodule

// >>> bench/flk_link_chk.sv
`timescale 1ns/1ps
module flk_link_chk #(
  parameter int unsigned FLASH_OP_CYCLES = 20
) (
  input wire logic sys_clk, // Core clock.
  input wire logic rst, // Reset, active high.
  input wire logic csr_wr, // Control write.
  input wire logic [7:0] csr_wdata, // Control value.
  input wire logic [7:0] csr_rdata, // Control readback.
  input wire logic lpm_req, // Load request.
  input wire logic spm_req, // Store request.
  input wire logic [15:0] z_ptr, // Pointer.
  input wire logic lpm_valid, // Load answer.
  input wire logic [7:0] lpm_data, // Load byte.
  input wire logic halt, // Flash operation running.
  input wire logic ee_busy // EEPROM busy, one clock late.
);
  // Counts the cycles of the current flash operation; reset does not stop it.
  logic [16:0] hcnt;
  always_ff @(posedge sys_clk) begin
    hcnt <= halt ? hcnt + 17'h00001 : 17'h00000;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_arm;
    csr_wr && csr_wdata[4:0] == 5'h09 && !halt ##1 csr_rdata[4:0] == 5'h09;
  endsequence
  sequence s_lock_rd;
    s_arm ##[0:2] (lpm_req && z_ptr == 16'h0001 && !ee_busy);
  endsequence
  a_answer_two: assert property (lpm_valid |-> $past(lpm_req, 2))
    else $error("load answer without a request two cycles before");
  a_lock_pad: assert property (s_lock_rd |-> ##2 lpm_valid && lpm_data[7:2] == 6'h3f)
    else $error("lock readback late or unused bits not one");
  a_read_clears: assert property (s_lock_rd |-> ##1 csr_rdata[4:0] == 5'h00)
    else $error("select bits kept after readback");
  a_arm_timeout: assert property (csr_wr && csr_wdata[4:0] == 5'h09 && !halt
    ##1 (csr_rdata[4:0] == 5'h09 && !lpm_req && !spm_req)[*4] |-> ##1 csr_rdata[4:0] == 5'h00)
    else $error("armed read did not expire on time");
  a_bad_value: assert property (csr_wr && csr_rdata[4:0] == 5'h00
    && !(csr_wdata[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}) |=> csr_rdata[4:0] == 5'h00)
    else $error("unlisted control value took effect");
  a_arm_shows: assert property (csr_wr && csr_wdata[4:0] == 5'h09 && csr_rdata[4:0] == 5'h00
    && !halt && !$past(lpm_req) |=> csr_rdata == 8'h09)
    else $error("read arm not shown at bits 3 and 0");
  a_busy_refuse: assert property (csr_wr && csr_rdata[4:0] == 5'h00
    && csr_wdata[4:0] inside {5'h11, 5'h05, 5'h03, 5'h01} ##1 ee_busy |-> csr_rdata[4:0] == 5'h00)
    else $error("programming accepted during EEPROM write");
  a_halt_length: assert property ($fell(halt) |-> hcnt == 17'(FLASH_OP_CYCLES))
    else $error("flash operation length wrong");
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import flk_pkg::*;
  localparam int unsigned OP_CYC = 20;
  logic sys_clk = 1'b0;
  logic rst, por, eeprom_write_busy, chip_erase, u_csr_wr, u_lpm, u_spm, u_sleep;
  logic [7:0] u_csr_val, fuse_low_byte, fuse_high_byte, pm_rdata, u_lpm_data, u_csr_read;
  logic [15:0] u_z, u_spm_data, pm_addr, buf_data, last_buf;
  logic u_lpm_valid, u_refused, u_halt, buf_load, buf_clear, page_erase, page_write;
  logic flash_busy, ext_prog_allow, ext_verify_allow, ext_fuse_wr_allow, ext_lock_wr_allow;
  logic [1:0] prot_mode;
  logic [7:0] bad [5] = '{8'h07, 8'h08, 8'h0b, 8'h19, 8'h1f};
  int fail_count = 0;
  int comparisons = 0;
  int n_erase = 0;
  int n_write = 0;
  int n_clear = 0;
  flk_link_if link();
  always #25 sys_clk = ~sys_clk;
  // Program memory model: each byte is its address xor a fixed pattern.
  assign pm_rdata = pm_addr[7:0] ^ 8'h5a;
  always @(posedge sys_clk) begin
    if (buf_load === 1'b1) last_buf <= buf_data;
    if (page_erase === 1'b1) n_erase <= n_erase + 1;
    if (page_write === 1'b1) n_write <= n_write + 1;
    if (buf_clear === 1'b1) n_clear <= n_clear + 1;
  end
  flk_ctrl #(.FLASH_OP_CYCLES(OP_CYC)) flk_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .por(por),
    .link(link), .eeprom_write_busy(eeprom_write_busy), .chip_erase(chip_erase),
    .fuse_low_byte(fuse_low_byte), .fuse_high_byte(fuse_high_byte), .pm_rdata(pm_rdata),
    .pm_addr(pm_addr), .buf_load(buf_load), .buf_data(buf_data), .buf_clear(buf_clear),
    .page_erase(page_erase), .page_write(page_write), .flash_busy(flash_busy),
    .prot_mode(prot_mode), .ext_prog_allow(ext_prog_allow), .ext_verify_allow(ext_verify_allow),
    .ext_fuse_wr_allow(ext_fuse_wr_allow), .ext_lock_wr_allow(ext_lock_wr_allow));
  flk_cpu flk_cpu_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .u_csr_wr(u_csr_wr),
    .u_csr_val(u_csr_val), .u_lpm(u_lpm), .u_spm(u_spm), .u_z(u_z), .u_spm_data(u_spm_data),
    .u_sleep(u_sleep), .u_lpm_valid(u_lpm_valid), .u_lpm_data(u_lpm_data),
    .u_refused(u_refused), .u_halt(u_halt), .u_csr_read(u_csr_read));
  flk_link_chk #(.FLASH_OP_CYCLES(OP_CYC)) flk_link_chk_inst (.sys_clk(sys_clk), .rst(rst),
    .csr_wr(link.csr_wr), .csr_wdata(link.csr_wdata), .csr_rdata(link.csr_rdata),
    .lpm_req(link.lpm_req), .spm_req(link.spm_req), .z_ptr(link.z_ptr),
    .lpm_valid(link.lpm_valid), .lpm_data(link.lpm_data), .halt(link.halt),
    .ee_busy(link.ee_busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_prot(input logic [5:0] exp);
    comparisons++;
    if ({prot_mode, ext_prog_allow, ext_verify_allow, ext_fuse_wr_allow,
        ext_lock_wr_allow} !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: protection outputs differ from %h", $time, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] v, input logic ee);
    @(negedge sys_clk);
    u_csr_wr = 1'b1;
    u_csr_val = v;
    eeprom_write_busy = ee;
    @(negedge sys_clk);
    u_csr_wr = 1'b0;
  endtask
  task automatic load(input logic [15:0] z, input logic [7:0] exp);
    int i;
    @(negedge sys_clk);
    u_z = z;
    u_lpm = 1'b1;
    @(negedge sys_clk);
    u_lpm = 1'b0;
    for (i = 0; i < 8 && u_lpm_valid !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 8) begin
      fail_count++;
      $display("CHECK FAILED at %0t: load answer missing", $time);
      stop_test();
    end
    chk({8'h00, u_lpm_data}, {8'h00, exp});
  endtask
  task automatic rd(input logic [15:0] z, input logic [7:0] exp);
    wr(8'h09, 1'b0);
    load(z, exp);
  endtask
  task automatic program_store_instr(input logic [15:0] d, input logic rst_mid);
    int i;
    @(negedge sys_clk);
    u_spm = 1'b1;
    u_spm_data = d;
    @(negedge sys_clk);
    u_spm = 1'b0;
    idle(4);
    if (rst_mid) begin
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      chk({15'h0000, flash_busy}, 16'h0001);
    end
    for (i = 0; i < 60 && (flash_busy !== 1'b0 || u_halt !== 1'b0); i++) idle(1);
    if (i == 60) begin
      fail_count++;
      $display("CHECK FAILED at %0t: flash operation never ended", $time);
      stop_test();
    end
    idle(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    por = 1'b1;
    {eeprom_write_busy, chip_erase, u_csr_wr, u_lpm, u_spm, u_sleep} = 6'h00;
    {u_csr_val, u_z, u_spm_data} = 40'h0000000000;
    // Fuse values are settled before any lock bit is programmed below.
    fuse_low_byte = 8'h64;
    fuse_high_byte = 8'hdf;
    idle(3);
    rst = 1'b0;
    por = 1'b0;
    idle(3);
    chk_prot(6'h1f);
    rd(16'h0001, 8'hff);
    rd(16'h0000, 8'h64);
    rd(16'h0003, 8'hdf);
    load(16'h0003, 8'h59);
    wr(8'h09, 1'b0);
    idle(2);
    chk({8'h00, u_csr_read}, 16'h0009);
    idle(3);
    load(16'h0000, 8'h5a);
    chk({8'h00, u_csr_read}, 16'h0000);
    wr(8'h09, 1'b1);
    load(16'h0001, 8'h5b);
    wr(8'h01, 1'b1);
    chk({15'h0000, u_refused}, 16'h0001);
    eeprom_write_busy = 1'b0;
    idle(6);
    foreach (bad[k]) begin
      wr(bad[k], 1'b0);
      load(16'h0001, 8'h5b);
    end
    wr(8'he9, 1'b0);
    load(16'h0001, 8'hff);
    wr(8'h03, 1'b1);
    program_store_instr(16'h0000, 1'b0);
    eeprom_write_busy = 1'b0;
    chk(16'(n_erase), 16'h0000);
    idle(3);
    wr(8'h01, 1'b0);
    program_store_instr(16'ha55a, 1'b0);
    chk(last_buf, 16'ha55a);
    wr(8'h11, 1'b0);
    program_store_instr(16'h0000, 1'b0);
    chk(16'(n_clear), 16'h0001);
    wr(8'h03, 1'b0);
    program_store_instr(16'h0000, 1'b0);
    chk(16'(n_erase), 16'h0001);
    wr(8'h05, 1'b0);
    program_store_instr(16'h0000, 1'b1);
    chk(16'(n_write), 16'h0001);
    wr(8'h09, 1'b0);
    program_store_instr(16'h0002, 1'b0);
    chk_prot(6'h25);
    rd(16'h0001, 8'hfe);
    wr(8'h09, 1'b0);
    program_store_instr(16'h0000, 1'b0);
    chk_prot(6'h30);
    wr(8'h09, 1'b0);
    program_store_instr(16'h0003, 1'b0);
    rd(16'h0001, 8'hfc);
    idle(1);
    chip_erase = 1'b1;
    idle(1);
    chip_erase = 1'b0;
    idle(3);
    chk_prot(6'h1f);
    rd(16'h0001, 8'hff);
    stop_test();
  end
endmodule
